// *** shared/rte_pkg.sv ***
// Package for the RAM-transfer and add execution slice of a 4-bit core.
// Assumes an APB slave with 8-bit byte addresses and 32-bit data.
package rte_pkg;
	// APB register byte offsets
	localparam logic [7:0] OFS_INSTR = 8'h00;     // Instruction issue
	localparam logic [7:0] OFS_ACC   = 8'h04;     // Accumulator and upper
	localparam logic [7:0] OFS_PTR   = 8'h08;     // Bank, file, digit
	localparam logic [7:0] OFS_FLAG  = 8'h0c;     // Carry, skip, page
	localparam logic [7:0] OFS_PCSP  = 8'h10;     // Counter and stack ptr
	// Field positions
	localparam int ACC_UP_LSB   = 4;              // Upper nibble in ACC
	localparam int PTR_X_LSB    = 4;              // File field in PTR
	localparam int PTR_Z_LSB    = 8;              // Bank field in PTR
	localparam int FLAG_CY_BIT  = 0;              // Carry in FLAG
	localparam int FLAG_SK_BIT  = 1;              // Skip pending in FLAG
	localparam int FLAG_LX_BIT  = 2;              // Load run open in FLAG
	localparam int FLAG_DR_LSB  = 4;              // Table page in FLAG
	localparam int PCSP_SP_LSB  = 16;             // Stack ptr in PCSP
	// Widths and depths
	localparam int PC_W         = 13;             // Program counter width
	localparam int SP_W         = 3;              // Stack pointer width
	localparam int STACK_DEPTH  = 8;              // Return slots
	localparam int RAM_AW       = 10;             // Bank, file, digit
	// Values after reset
	localparam logic [3:0]      RST_NIB = 4'h0;   // Nibble registers
	localparam logic [1:0]      RST_Z   = 2'h0;   // Bank register
	localparam logic [2:0]      RST_DR  = 3'h0;   // Table page register
	localparam logic [PC_W-1:0] RST_PC  = 13'h0000; // Program counter
	localparam logic [SP_W-1:0] RST_SP  = 3'h7;   // First push lands on 0
	// Instruction codes, full or upper part
	localparam logic [9:0] OP_AM     = 10'h00a;   // Add memory
	localparam logic [9:0] OP_AMC    = 10'h00b;   // Add memory with carry
	localparam logic [9:0] OP_INY    = 10'h013;   // Digit increment
	localparam logic [9:0] OP_DEY    = 10'h017;   // Digit decrement
	localparam logic [9:0] OP_TASP   = 10'h050;   // Stack ptr to acc
	localparam logic [7:0] OPH_LZ    = 8'h12;     // Bank load
	localparam logic [5:0] OPH_TAM   = 6'h2c;     // RAM to acc
	localparam logic [5:0] OPH_XAM   = 6'h2d;     // Swap
	localparam logic [5:0] OPH_SWAP_INCREMENT_OP  = 6'h2e;     // Swap, increment
	localparam logic [5:0] OPH_SWAP_DECREMENT_OP  = 6'h2f;     // Swap, decrement
	localparam logic [5:0] OPH_TMA   = 6'h2b;     // Acc to RAM
	localparam logic [5:0] OPH_LA    = 6'h07;     // Load immediate
	localparam logic [5:0] OPH_AN    = 6'h06;     // Add immediate
	localparam logic [3:0] OPH_TABLE_READ_OP  = 4'h2;      // Table read
	localparam logic [1:0] OPH_LXY   = 2'h3;      // File and digit load
	localparam logic [3:0] DIG_WRAP_UP = 4'h0;    // Skip value on increment
	localparam logic [3:0] DIG_WRAP_DN = 4'hf;    // Skip value on decrement
	// Bus and table-read sequencer states
	typedef enum logic [4:0] {
		ST_IDLE  = 5'b00001,
		ST_PUSH  = 5'b00010,
		ST_FETCH = 5'b00100,
		ST_POP   = 5'b01000,
		ST_ACK   = 5'b10000
	} rte_state_t;
endpackage

// *** hdl/rte_nib_add.sv ***
// Four-bit adder with carry in and carry out.
// Purely combinational; the caller registers the result.
`timescale 1ns/100ps
module rte_nib_add
	import rte_pkg::*;
(
	input  wire logic [3:0] a,    // First operand
	input  wire logic [3:0] b,    // Second operand
	input  wire logic       cin,  // Carry in
	output logic      [3:0] sum,  // Four-bit sum
	output logic            cout  // Carry out of bit 3
);
	////////////////////////////////////////////////////////////////////
	// Sum widened by one bit to catch the carry
	always_comb begin
		{cout, sum} = {1'b0, a} + {1'b0, b} + {4'h0, cin};
	end
endmodule

// *** hdl/rte_ram.sv ***
// Data RAM of nibbles in flip-flops, addressed by bank, file and digit.
// Read is combinational; write lands at the clock edge.
`timescale 1ns/100ps
module rte_ram
	import rte_pkg::*;
(
	input  wire logic              pclk,    // Core clock
	input  wire logic              presetn, // Async reset, active low
	input  wire logic [RAM_AW-1:0] addr,    // Nibble index
	input  wire logic              we,      // Write strobe
	input  wire logic [3:0]        wdata,   // Write nibble
	output logic      [3:0]        rdata    // Read nibble
);
	localparam int DEPTH = 1 << RAM_AW;     // Number of nibbles
	logic [3:0] mem [DEPTH];                // Storage
	////////////////////////////////////////////////////////////////////
	// One flip-flop group per entry
	for (genvar i = 0; i < DEPTH; i++) begin : g_ent
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				mem[i] <= RST_NIB;
			end else if (we && addr == RAM_AW'(i)) begin
				mem[i] <= wdata;
			end
		end
	end
	////////////////////////////////////////////////////////////////////
	// Read port
	assign rdata = mem[addr];
endmodule

// *** hdl/rte_exec.sv ***
// Execution slice: RAM pointer loads, transfers, table read and adds.
// Instructions are issued by APB writes; state is visible over APB.
// Program ROM answers one clock after rom_addr is presented.
//
// Summary of operation
// - Stack pointer value copied into accumulator
// - Load file and digit fields together
// - Runs of file-digit loads: later ones skipped
// - Bank load takes immediate bank field
// - Digit increment wraps, skips on zero
// - Digit decrements wrap, skip on fifteen
// - RAM to accumulator, then file XOR immediate
// - Swap accumulator with RAM, then file XOR
// - Swap-increment also increments digit, skips on zero
// - Accumulator to RAM, then file XOR immediate
// - Load immediate into accumulator, one cycle
// - Table read: three cycles, push, page address
// - Table word split upper/acc, then stack pop
// - Add memory to accumulator, four-bit sum
// - Add memory and carry, carry updated
// - Add immediate to accumulator, one cycle
// - File XOR immediate uses low four bits
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/100ps
module rte_exec
	import rte_pkg::*;
(
	input  wire logic            pclk,     // Core clock, 250 MHz
	input  wire logic            presetn,  // Async reset, active low
	input  wire logic            psel,     // APB select
	input  wire logic            penable,  // APB access phase
	input  wire logic            pwrite,   // APB direction
	input  wire logic [7:0]      paddr,    // APB byte address
	input  wire logic [31:0]     pwdata,   // APB write data
	output logic      [31:0]     prdata,   // APB read data
	output logic                 pready,   // APB ready
	output logic                 pslverr,  // APB error on unmapped
	output logic      [PC_W-1:0] rom_addr, // Table read ROM address
	input  wire logic [9:0]      rom_data  // ROM word, one clock late
);
	////////////////////////////////////////////////////////////////////
	// Declarations
	rte_state_t      state, next_state;        // Bus sequencer
	logic            next_pready;              // Ready flop input
	logic            next_pslverr;             // Error flop input
	logic [31:0]     next_prdata;              // Read data input
	logic [PC_W-1:0] next_rom_addr;            // ROM address input
	logic [3:0]      acc, next_acc;            // Accumulator
	logic [3:0]      upper, next_upper;        // Upper nibble register
	logic [3:0]      xf, next_xf;              // File register
	logic [3:0]      yd, next_yd;              // Digit register
	logic [1:0]      zb, next_zb;              // Bank register
	logic [2:0]      dr, next_dr;              // Table page register
	logic            cy, next_cy;              // Carry flag
	logic            skip, next_skip;          // Skip pending
	logic            lxy_run, next_lxy_run;    // Last issue was a file/digit load
	logic [PC_W-1:0] pc, next_pc;              // Program counter
	logic [SP_W-1:0] sp, next_sp;              // Stack pointer
	logic [PC_W-1:0] stk [STACK_DEPTH];        // Return stack slots
	logic            push;                     // Write stack slot
	logic [9:0]      op;                       // Issued instruction
	logic            issue;                    // Instruction write taken
	logic            skipped;                  // Issue has no effect
	logic            exec;                     // Issue takes effect
	logic            is_lxy;                   // Decoded load file/digit
	logic [3:0]      ram_rd;                   // Pointed nibble
	logic            ram_we;                   // RAM write strobe
	logic [3:0]      ram_wd;                   // RAM write nibble
	logic [3:0]      add_b;                    // Adder second operand
	logic            add_ci;                   // Adder carry in
	logic [3:0]      add_s;                    // Adder sum
	logic            add_co;                   // Adder carry out
	logic [3:0]      y_inc, y_dec;             // Digit neighbours
	logic            acc_phase;                // Access phase seen
	////////////////////////////////////////////////////////////////////
	// Decode of the bus access
	assign acc_phase = psel && penable && state == ST_IDLE;
	assign op        = pwdata[9:0];
	assign issue     = acc_phase && pwrite && paddr == OFS_INSTR;
	assign is_lxy    = op[9:8] == OPH_LXY;
	assign skipped   = skip || (lxy_run && is_lxy);
	assign exec      = issue && !skipped;
	assign y_inc     = yd + 4'h1;
	assign y_dec     = yd - 4'h1;
	////////////////////////////////////////////////////////////////////
	// Pointed RAM and the adder
	rte_ram u_ram (
		.pclk    (pclk),
		.presetn (presetn),
		.addr    ({zb, xf, yd}),
		.we      (ram_we),
		.wdata   (ram_wd),
		.rdata   (ram_rd)
	);
	// Memory adds take the nibble; immediate adds take the low field
	assign add_b  = (op[9:4] == OPH_AN) ? op[3:0] : ram_rd;
	assign add_ci = (op == OP_AMC) ? cy : 1'b0;
	rte_nib_add u_add (
		.a    (acc),
		.b    (add_b),
		.cin  (add_ci),
		.sum  (add_s),
		.cout (add_co)
	);
	////////////////////////////////////////////////////////////////////
	// Next-state logic for the core registers
	always_comb begin
		next_acc     = acc;
		next_upper   = upper;
		next_xf      = xf;
		next_yd      = yd;
		next_zb      = zb;
		next_dr      = dr;
		next_cy      = cy;
		next_skip    = skip;
		next_lxy_run = lxy_run;
		next_pc      = pc;
		next_sp      = sp;
		push         = 1'b0;
		ram_we       = 1'b0;
		ram_wd       = acc;
		if (issue) begin
			// Fetched either way; a skip is consumed
			next_pc      = pc + 13'h0001;
			next_skip    = 1'b0;
			next_lxy_run = is_lxy;
		end
		if (exec) begin
			if (op == OP_TASP) begin
				next_acc = {1'b0, sp};
			end else if (is_lxy) begin
				next_xf = op[7:4];
				next_yd = op[3:0];
			end else if (op[9:2] == OPH_LZ) begin
				next_zb = op[1:0];
			end else if (op == OP_INY) begin
				next_yd   = y_inc;
				next_skip = y_inc == DIG_WRAP_UP;
			end else if (op == OP_DEY) begin
				next_yd   = y_dec;
				next_skip = y_dec == DIG_WRAP_DN;
			end else if (op[9:4] == OPH_TAM) begin
				next_acc = ram_rd;
				next_xf  = xf ^ op[3:0];
			end else if (op[9:4] == OPH_XAM || op[9:4] == OPH_SWAP_INCREMENT_OP ||
					op[9:4] == OPH_SWAP_DECREMENT_OP) begin
				// Swap; RAM address is the old pointer this cycle
				next_acc = ram_rd;
				ram_we   = 1'b1;
				next_xf  = xf ^ op[3:0];
				if (op[9:4] == OPH_SWAP_INCREMENT_OP) begin
					next_yd   = y_inc;
					next_skip = y_inc == DIG_WRAP_UP;
				end else if (op[9:4] == OPH_SWAP_DECREMENT_OP) begin
					next_yd   = y_dec;
					next_skip = y_dec == DIG_WRAP_DN;
				end
			end else if (op[9:4] == OPH_TMA) begin
				ram_we  = 1'b1;
				next_xf = xf ^ op[3:0];
			end else if (op[9:4] == OPH_LA) begin
				next_acc = op[3:0];
			end else if (op == OP_AM || op[9:4] == OPH_AN) begin
				next_acc = add_s;
			end else if (op == OP_AMC) begin
				next_acc = add_s;
				next_cy  = add_co;
			end else if (op[9:6] == OPH_TABLE_READ_OP) begin
				next_sp = sp + 3'h1;
			end
		end else if (acc_phase && pwrite) begin
			// Direct register writes from software
			unique case (paddr)
				OFS_ACC: begin
					next_acc   = pwdata[3:0];
					next_upper = pwdata[ACC_UP_LSB +: 4];
				end
				OFS_PTR: begin
					next_yd = pwdata[3:0];
					next_xf = pwdata[PTR_X_LSB +: 4];
					next_zb = pwdata[PTR_Z_LSB +: 2];
				end
				OFS_FLAG: begin
					next_cy = pwdata[FLAG_CY_BIT];
					next_dr = pwdata[FLAG_DR_LSB +: 3];
				end
				OFS_PCSP: begin
					next_pc = pwdata[PC_W-1:0];
					next_sp = pwdata[PCSP_SP_LSB +: SP_W];
				end
				default: begin
				end
			endcase
		end
		// Table read sequence after the issue cycle
		if (state == ST_PUSH) begin
			push = 1'b1;
		end
		if (state == ST_FETCH) begin
			next_upper = rom_data[7:4];
			next_acc   = rom_data[3:0];
		end
		if (state == ST_POP) begin
			next_pc = stk[sp];
			next_sp = sp - 3'h1;
		end
	end
	////////////////////////////////////////////////////////////////////
	// Core registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc     <= RST_NIB;
			upper   <= RST_NIB;
			xf      <= RST_NIB;
			yd      <= RST_NIB;
			zb      <= RST_Z;
			dr      <= RST_DR;
			cy      <= 1'b0;
			skip    <= 1'b0;
			lxy_run <= 1'b0;
			pc      <= RST_PC;
			sp      <= RST_SP;
		end else begin
			acc     <= next_acc;
			upper   <= next_upper;
			xf      <= next_xf;
			yd      <= next_yd;
			zb      <= next_zb;
			dr      <= next_dr;
			cy      <= next_cy;
			skip    <= next_skip;
			lxy_run <= next_lxy_run;
			pc      <= next_pc;
			sp      <= next_sp;
		end
	end
	////////////////////////////////////////////////////////////////////
	// Return stack slots, one per entry
	for (genvar i = 0; i < STACK_DEPTH; i++) begin : g_stk
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				stk[i] <= RST_PC;
			end else if (push && sp == SP_W'(i)) begin
				stk[i] <= pc;
			end
		end
	end
	////////////////////////////////////////////////////////////////////
	// Bus sequencer and its outputs
	always_comb begin
		next_state    = state;
		next_pready   = 1'b0;
		next_pslverr  = 1'b0;
		next_prdata   = prdata;
		next_rom_addr = rom_addr;
		unique case (state)
			ST_IDLE: begin
				if (acc_phase) begin
					next_state = ST_ACK;
					if (exec && op[9:6] == OPH_TABLE_READ_OP) begin
						next_state    = ST_PUSH;
						next_rom_addr = {op[5:0], dr, acc};
					end
					unique case (paddr)
						OFS_ACC:  next_prdata = {24'h0, upper, acc};
						OFS_PTR:  next_prdata = {22'h0, zb, xf, yd};
						OFS_FLAG: next_prdata = {25'h0, dr, 1'b0,
							lxy_run, skip, cy};
						OFS_PCSP: next_prdata = {13'h0, sp, 3'h0, pc};
						OFS_INSTR: next_prdata = 32'h0;
						default: begin
							next_prdata  = 32'h0;
							next_pslverr = 1'b1;
						end
					endcase
					next_pready = next_state == ST_ACK;
				end
			end
			ST_PUSH:  next_state = ST_FETCH;
			ST_FETCH: next_state = ST_POP;
			ST_POP: begin
				next_state  = ST_ACK;
				next_pready = 1'b1;
			end
			ST_ACK:   next_state = ST_IDLE;
			default:  next_state = ST_IDLE;
		endcase
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state    <= ST_IDLE;
			pready   <= 1'b0;
			pslverr  <= 1'b0;
			prdata   <= 32'h0;
			rom_addr <= RST_PC;
		end else begin
			state    <= next_state;
			pready   <= next_pready;
			pslverr  <= next_pslverr;
			prdata   <= next_prdata;
			rom_addr <= next_rom_addr;
		end
	end
	////////////////////////////////////////////////////////////////////
	// Checks
	property p_tasp;
		@(posedge pclk) disable iff (!presetn)
		exec && op == OP_TASP |=> acc == {1'b0, $past(sp)};
	endproperty
	a_tasp: assert property (p_tasp) else $error("acc not stack ptr");
	property p_lxy;
		@(posedge pclk) disable iff (!presetn)
		exec && is_lxy |=> {xf, yd} == $past(op[7:0]);
	endproperty
	a_lxy: assert property (p_lxy) else $error("file/digit load");
	property p_lxy_run;
		@(posedge pclk) disable iff (!presetn)
		issue && lxy_run && is_lxy |=> $stable(xf) && $stable(yd);
	endproperty
	a_lxy_run: assert property (p_lxy_run) else $error("run loaded");
	property p_iny;
		@(posedge pclk) disable iff (!presetn)
		exec && op == OP_INY |=> yd == $past(yd) + 4'h1 &&
			skip == (yd == 4'h0);
	endproperty
	a_iny: assert property (p_iny) else $error("increment skip");
	property p_dey;
		@(posedge pclk) disable iff (!presetn)
		exec && op == OP_DEY |=> skip == (yd == 4'hf);
	endproperty
	a_dey: assert property (p_dey) else $error("decrement skip");
	property p_tam;
		@(posedge pclk) disable iff (!presetn)
		exec && op[9:4] == OPH_TAM |=> acc == $past(ram_rd) &&
			xf == ($past(xf) ^ $past(op[3:0]));
	endproperty
	a_tam: assert property (p_tam) else $error("ram to acc");
	property p_table_read_op;
		@(posedge pclk) disable iff (!presetn)
		exec && op[9:6] == OPH_TABLE_READ_OP |=> !pready [*3] ##1 pready;
	endproperty
	a_table_read_op: assert property (p_table_read_op) else $error("table timing");
	property p_tab_pop;
		@(posedge pclk) disable iff (!presetn)
		state == ST_FETCH |=> acc == $past(rom_data[3:0]) ##1
			sp == $past(sp, 2) - 3'h1;
	endproperty
	a_tab_pop: assert property (p_tab_pop) else $error("table word");
	logic [3:0] add_s_q;                        // Sum seen at issue
	property p_am;
		@(posedge pclk) disable iff (!presetn)
		exec && op == OP_AM |=> acc == add_s_q && cy == $past(cy);
	endproperty
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) add_s_q <= RST_NIB;
		else add_s_q <= acc + ram_rd;
	end
	a_am: assert property (p_am) else $error("add memory");
	property p_skip;
		@(posedge pclk) disable iff (!presetn)
		issue && skipped |=> $stable(acc) && $stable(cy) && !skip;
	endproperty
	a_skip: assert property (p_skip) else $error("skip had effect");
	c_table_read_op: cover property (@(posedge pclk) state == ST_POP);
	c_skip: cover property (@(posedge pclk) issue && skipped);
	c_amc:  cover property (@(posedge pclk) exec && op == OP_AMC && add_co);
endmodule

// *** verification/rte_rom_model.sv ***
// Program ROM model for the table-read path of the execution slice.
// Assumes the ROM word is taken one clock after rom_addr is presented.
`timescale 1ns/100ps
module rte_rom_model
	import rte_pkg::*;
(
	input  wire logic            pclk,     // Core clock
	input  wire logic [PC_W-1:0] rom_addr, // Table read address
	output logic      [9:0]      rom_data  // Word, one clock late
);
	////////////////////////////////////////////////////////////////////
	// Registered lookup; content is a fixed scramble of the address
	always_ff @(posedge pclk) begin
		rom_data <= rom_addr[9:0] ^ 10'h3c6;
	end
endmodule

// *** verification/rte_exec_tb.sv ***
// Self-checking bench for the execution slice, driven over APB.
// Assumes the ROM model in its own file and a 250 MHz core clock.
`timescale 1ns/100ps
module rte_exec_tb;
	import rte_pkg::*;
	logic            pclk = 1'b0;     // Core clock
	logic            presetn = 1'b0;  // Reset, active low
	logic            psel = 1'b0;     // APB select
	logic            penable = 1'b0;  // APB access phase
	logic            pwrite = 1'b0;   // APB direction
	logic [7:0]      paddr = 8'h00;   // APB address
	logic [31:0]     pwdata = 32'h0;  // APB write data
	logic [31:0]     prdata;          // APB read data
	logic            pready;          // APB ready
	logic            pslverr;         // APB error
	logic [PC_W-1:0] rom_addr;        // ROM address
	logic [9:0]      rom_data;        // ROM word
	int              err_count = 0;   // Mismatches
	int              num_checks = 0;  // Comparisons
	int              cyc;             // Access phase length
	logic [31:0]     q;               // Last read data
	logic            e;               // Last error flag
	////////////////////////////////////////////////////////////////////
	// Clock and instances
	always #2 pclk = ~pclk;
	rte_exec u_rte_exec (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rom_addr(rom_addr), .rom_data(rom_data));
	rte_rom_model u_rte_rom_model (.pclk(pclk), .rom_addr(rom_addr),
		.rom_data(rom_data));
	////////////////////////////////////////////////////////////////////
	// Verdict and end of run
	task automatic summarize;
		$display("Checks %0d, mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// Compare and report
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			$display("Error at %0t: got %h expected %h", $time, got, exp);
			err_count++;
		end
	endtask
	// One APB transfer; holds until pready is sampled high or 100 cycles pass
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		cyc = 0;
		do begin
			@(posedge pclk);
			cyc++;
		end while (pready !== 1'b1 && cyc < 100);
		if (cyc >= 100) begin
			err_count++;
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Register write, instruction issue, masked read check
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic iss(input logic [9:0] op);
		apb(1'b1, OFS_INSTR, {22'h0, op});
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(q & m, exp);
	endtask
	task automatic done(input string name);
		$display("Test %s finished", name);
	endtask
	////////////////////////////////////////////////////////////////////
	// Watchdog, well beyond the expected run length
	initial begin
		#40000;
		err_count++;
		summarize();
	end
	////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rd(OFS_ACC, 32'hffffffff, 32'h0);
		rd(OFS_PTR, 32'hffffffff, 32'h0);
		rd(OFS_FLAG, 32'hffffffff, 32'h0);
		rd(OFS_PCSP, 32'hffffffff, 32'h00070000);
		rd(8'h14, 32'hffffffff, 32'h0);
		chk({31'h0, e}, 32'h1);
		done("reset");
		iss(OP_TASP);
		chk(cyc, 2);
		rd(OFS_ACC, 32'hff, 32'h07);
		done("stack");
		iss({OPH_LXY, 4'ha, 4'h5});
		iss({OPH_LXY, 4'h1, 4'h2});
		rd(OFS_PTR, 32'h3ff, 32'h0a5);
		rd(OFS_FLAG, 32'h2, 32'h0);
		iss({OPH_LZ, 2'h3});
		rd(OFS_PTR, 32'h3ff, 32'h3a5);
		iss({OPH_LXY, 4'h1, 4'h2});
		rd(OFS_PTR, 32'h3ff, 32'h312);
		done("loads");
		wr(OFS_PTR, 32'h00f);
		iss(OP_INY);
		rd(OFS_PTR, 32'h3ff, 32'h000);
		rd(OFS_FLAG, 32'h2, 32'h2);
		iss({OPH_LA, 4'h5});
		rd(OFS_ACC, 32'hff, 32'h07);
		iss({OPH_LA, 4'h9});
		rd(OFS_ACC, 32'hff, 32'h09);
		iss(OP_DEY);
		iss({OPH_AN, 4'h1});
		rd(OFS_ACC, 32'hff, 32'h09);
		rd(OFS_PTR, 32'h3ff, 32'h00f);
		iss(OP_DEY);
		rd(OFS_FLAG, 32'h2, 32'h0);
		done("digit");
		wr(OFS_PTR, 32'h012);
		wr(OFS_ACC, 32'h6);
		iss({OPH_TMA, 4'h3});
		rd(OFS_PTR, 32'h3ff, 32'h022);
		wr(OFS_PTR, 32'h012);
		iss({OPH_LA, 4'h4});
		iss({OPH_TAM, 4'h0});
		rd(OFS_ACC, 32'hff, 32'h06);
		iss({OPH_LA, 4'h9});
		iss({OPH_XAM, 4'hf});
		rd(OFS_ACC, 32'hff, 32'h06);
		rd(OFS_PTR, 32'h3ff, 32'h0e2);
		wr(OFS_PTR, 32'h012);
		iss({OPH_TAM, 4'h0});
		rd(OFS_ACC, 32'hff, 32'h09);
		wr(OFS_PTR, 32'h01f);
		iss({OPH_LA, 4'h3});
		iss({OPH_SWAP_INCREMENT_OP, 4'h1});
		rd(OFS_PTR, 32'h3ff, 32'h000);
		iss({OPH_LA, 4'h7});
		wr(OFS_PTR, 32'h01f);
		iss({OPH_TAM, 4'h0});
		rd(OFS_ACC, 32'hff, 32'h03);
		wr(OFS_PTR, 32'h010);
		iss({OPH_LA, 4'h5});
		iss({OPH_SWAP_DECREMENT_OP, 4'h2});
		rd(OFS_PTR, 32'h3ff, 32'h03f);
		iss({OPH_LA, 4'h7});
		wr(OFS_PTR, 32'h010);
		iss({OPH_TAM, 4'h0});
		rd(OFS_ACC, 32'hff, 32'h05);
		done("transfer");
		wr(OFS_PTR, 32'h012);
		wr(OFS_FLAG, 32'h1);
		wr(OFS_ACC, 32'h8);
		iss(OP_AM);
		rd(OFS_ACC, 32'hff, 32'h01);
		rd(OFS_FLAG, 32'h1, 32'h1);
		iss(OP_AMC);
		rd(OFS_ACC, 32'hff, 32'h0b);
		rd(OFS_FLAG, 32'h1, 32'h0);
		iss(OP_AMC);
		rd(OFS_ACC, 32'hff, 32'h04);
		rd(OFS_FLAG, 32'h1, 32'h1);
		iss({OPH_AN, 4'hf});
		rd(OFS_ACC, 32'hff, 32'h03);
		rd(OFS_FLAG, 32'h1, 32'h1);
		done("add");
		wr(OFS_FLAG, 32'h51);
		wr(OFS_ACC, 32'h3);
		wr(OFS_PCSP, 32'h00020123);
		iss({OPH_TABLE_READ_OP, 6'h2a});
		chk(cyc, 5);
		rd(OFS_ACC, 32'hff, 32'h95);
		rd(OFS_PCSP, 32'h00071fff, 32'h00020124);
		done("table");
		summarize();
	end
endmodule
